// file: hw/sleep_mask_defs.svh
// Constants for the sleep-state error mask register bank.
// Assumes an 8-bit register address space reached by the serial
// management bus slave of the monitor.
//
// Functional notes
// R1: In the deep sleep state each fan input error (inputs 1 to 4, bits 0 to 3) is hidden while its mask bit is set, and all four bits are set after reset.
// R2: In the deep sleep state the zone 1 and 2 temperature and diode fault errors are hidden while bit 3 of the deep sleep temperature/voltage mask is set, and that bit is clear after reset.
// R3: In the off state the errors of general-purpose inputs 0 to 3 are hidden while their mask bits 0 to 3 are set.
// R4: In the off state the errors of general-purpose inputs 4 to 7 are hidden while their mask bits 4 to 7 are set, and all eight bits are set after reset.
// R5: In the deep sleep state the limit errors of analog channels 12, 13 and 14 are hidden while mask bits 0 to 2 are set, and those bits are set after reset.
// R6: A mask register acts only while the sleep state field selects its own state, and nothing is hidden in the working state.
// R7: The sleep state field is forced to the off state whenever the reset input is asserted.

`ifndef SLEEP_MASK_DEFS_SVH
`define SLEEP_MASK_DEFS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define S3_FAN_INPUT_MASK_OFS    8'hE8
`define S3_TEMP_VOLTAGE_MASK_OFS 8'hE9
`define S45_INPUT_MASK_OFS       8'hEA

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define S3_FAN_INPUT_MASK_RST    4'hF
`define S3_TEMP_VOLTAGE_MASK_RST 4'h7
`define S45_INPUT_MASK_RST       8'hFF

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define FAN_MASK_MSB             3
`define TV_ANALOG_MSB            2
`define TV_ZONE_TEMP_BIT         3
`define READ_ZERO                8'h00

`endif

// file: hw/sleep_mask_pkg.sv
// Types for the sleep-state error mask register bank.
// Assumes the constants header is included by the design file.

package sleep_mask_pkg;

  // ----------------------------------------------------------------
  // Sleep state encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLEEP_WORKING = 2'b00,
    SLEEP_LIGHT   = 2'b01,
    SLEEP_DEEP    = 2'b10,
    SLEEP_OFF     = 2'b11
  } sleep_state_t;

  // ----------------------------------------------------------------
  // Error source vector
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] gpi;
    logic       zone_temp;
    logic [2:0] analog;
    logic [3:0] fan;
  } err_vec_t;

  // ----------------------------------------------------------------
  // Register access request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // ----------------------------------------------------------------
  // Whole block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]   s3_fan_input_mask;
    logic [3:0]   s3_temp_voltage_mask;
    logic [7:0]   s45_input_mask;
    sleep_state_t sleep_state;
    logic [7:0]   rd_data;
    logic         rd_valid;
    err_vec_t     err_rep;
  } mask_state_t;

endpackage

// file: hw/sleep_state_error_masks.sv
// Sleep-state error mask register bank and error gating.
// Assumes the serial bus slave presents one-cycle read and write
// strobes with an 8-bit address, and that error inputs are levels.

`timescale 1ns/100ps
`include "sleep_mask_defs.svh"

module sleep_state_error_masks #(
  parameter int ADDR_W   = 8,
  parameter int FAN_N    = 4,
  parameter int ANALOG_N = 3,
  parameter int GPI_N    = 8
) (
  // Clock and reset.
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // Device reset pin, active high.
  input  wire logic                      reset_in,
  // Sleep state field update from the control register.
  input  wire logic                      state_wr,
  input  wire logic [1:0]                state_wdata,
  // Register access from the bus slave.
  input  wire sleep_mask_pkg::reg_req_t  reg_req,
  output logic [7:0]                     reg_rdata,
  output logic                           reg_rvalid,
  // Raw and reported errors.
  input  wire sleep_mask_pkg::err_vec_t  err_raw,
  output sleep_mask_pkg::err_vec_t       err_rep,
  // Current sleep state.
  output sleep_mask_pkg::sleep_state_t   sleep_state
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W != 8) begin : g_bad_addr
    $error("Address width must be 8.");
  end

  if (FAN_N != 4) begin : g_bad_fan
    $error("Fan input count must be 4.");
  end

  if (ANALOG_N != 3) begin : g_bad_analog
    $error("Analog channel count must be 3.");
  end

  if (GPI_N != 8) begin : g_bad_gpi
    $error("General-purpose input count must be 8.");
  end

  localparam int ERR_W = FAN_N + ANALOG_N + GPI_N + 1;

  if (ERR_W != $bits(sleep_mask_pkg::err_vec_t)) begin : g_bad_vec
    $error("Error vector layout does not match the counts.");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sleep_mask_pkg::mask_state_t st_r;
  sleep_mask_pkg::mask_state_t st_nxt;
  sleep_mask_pkg::err_vec_t    hide;

  // ----------------------------------------------------------------
  // Named mask fields
  // ----------------------------------------------------------------
  logic fan_in1_deep_sleep_mask;
  logic fan_in2_deep_sleep_mask;
  logic fan_in3_deep_sleep_mask;
  logic fan_in4_deep_sleep_mask;

  logic analog_ch12_deep_sleep_mask;
  logic analog_ch13_deep_sleep_mask;
  logic analog_ch14_deep_sleep_mask;

  logic zone_temp_deep_sleep_mask;

  logic input0_off_state_mask;
  logic input1_off_state_mask;
  logic input2_off_state_mask;
  logic input3_off_state_mask;
  logic input4_off_state_mask;
  logic input5_off_state_mask;
  logic input6_off_state_mask;
  logic input7_off_state_mask;

  assign fan_in1_deep_sleep_mask     = st_r.s3_fan_input_mask[0];
  assign fan_in2_deep_sleep_mask     = st_r.s3_fan_input_mask[1];
  assign fan_in3_deep_sleep_mask     = st_r.s3_fan_input_mask[2];
  assign fan_in4_deep_sleep_mask     = st_r.s3_fan_input_mask[3];
  assign analog_ch12_deep_sleep_mask = st_r.s3_temp_voltage_mask[0];
  assign analog_ch13_deep_sleep_mask = st_r.s3_temp_voltage_mask[1];
  assign analog_ch14_deep_sleep_mask = st_r.s3_temp_voltage_mask[2];
  assign zone_temp_deep_sleep_mask   =
    st_r.s3_temp_voltage_mask[`TV_ZONE_TEMP_BIT];
  assign input0_off_state_mask       = st_r.s45_input_mask[0];
  assign input1_off_state_mask       = st_r.s45_input_mask[1];
  assign input2_off_state_mask       = st_r.s45_input_mask[2];
  assign input3_off_state_mask       = st_r.s45_input_mask[3];
  assign input4_off_state_mask       = st_r.s45_input_mask[4];
  assign input5_off_state_mask       = st_r.s45_input_mask[5];
  assign input6_off_state_mask       = st_r.s45_input_mask[6];
  assign input7_off_state_mask       = st_r.s45_input_mask[7];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    hide   = '0;
    st_nxt.rd_valid = 1'b0;

    // Sleep state field.
    if (reset_in) begin
      st_nxt.sleep_state = sleep_mask_pkg::SLEEP_OFF; // R7
    end else if (state_wr) begin
      st_nxt.sleep_state = sleep_mask_pkg::sleep_state_t'(state_wdata);
    end

    // Register writes; reserved bits are dropped.
    if (reg_req.wr) begin
      case (reg_req.addr)
        `S3_FAN_INPUT_MASK_OFS: begin
          st_nxt.s3_fan_input_mask = reg_req.wdata[`FAN_MASK_MSB:0];
        end
        `S3_TEMP_VOLTAGE_MASK_OFS: begin
          st_nxt.s3_temp_voltage_mask = reg_req.wdata[3:0];
        end
        `S45_INPUT_MASK_OFS: begin
          st_nxt.s45_input_mask = reg_req.wdata;
        end
        default: begin
          st_nxt.s45_input_mask = st_r.s45_input_mask;
        end
      endcase
    end

    // Register reads; unmapped addresses read zero.
    if (reg_req.rd) begin
      st_nxt.rd_valid = 1'b1;
      case (reg_req.addr)
        `S3_FAN_INPUT_MASK_OFS: begin
          st_nxt.rd_data = {4'h0, st_r.s3_fan_input_mask};
        end
        `S3_TEMP_VOLTAGE_MASK_OFS: begin
          st_nxt.rd_data = {4'h0, st_r.s3_temp_voltage_mask};
        end
        `S45_INPUT_MASK_OFS: begin
          st_nxt.rd_data = st_r.s45_input_mask;
        end
        default: begin
          st_nxt.rd_data = `READ_ZERO;
        end
      endcase
    end

    // Mask selection by sleep state.
    case (st_r.sleep_state)
      sleep_mask_pkg::SLEEP_DEEP: begin
        hide.fan[0]    = fan_in1_deep_sleep_mask; // R1 R6
        hide.fan[1]    = fan_in2_deep_sleep_mask; // R1
        hide.fan[2]    = fan_in3_deep_sleep_mask; // R1
        hide.fan[3]    = fan_in4_deep_sleep_mask; // R1
        hide.analog[0] = analog_ch12_deep_sleep_mask; // R5
        hide.analog[1] = analog_ch13_deep_sleep_mask; // R5
        hide.analog[2] = analog_ch14_deep_sleep_mask; // R5
        hide.zone_temp = zone_temp_deep_sleep_mask; // R2
      end
      sleep_mask_pkg::SLEEP_OFF: begin
        hide.gpi[0] = input0_off_state_mask; // R3 R6
        hide.gpi[1] = input1_off_state_mask; // R3
        hide.gpi[2] = input2_off_state_mask; // R3
        hide.gpi[3] = input3_off_state_mask; // R3
        hide.gpi[4] = input4_off_state_mask; // R4
        hide.gpi[5] = input5_off_state_mask; // R4
        hide.gpi[6] = input6_off_state_mask; // R4
        hide.gpi[7] = input7_off_state_mask; // R4
      end
      sleep_mask_pkg::SLEEP_LIGHT: begin
        hide = '0; // R6
      end
      sleep_mask_pkg::SLEEP_WORKING: begin
        hide = '0; // R6
      end
      default: begin
        hide = '0;
      end
    endcase

    // Reported errors.
    st_nxt.err_rep.gpi       = err_raw.gpi & ~hide.gpi;
    st_nxt.err_rep.zone_temp = err_raw.zone_temp & ~hide.zone_temp;
    st_nxt.err_rep.analog    = err_raw.analog & ~hide.analog;
    st_nxt.err_rep.fan       = err_raw.fan & ~hide.fan;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r.s3_fan_input_mask    <= `S3_FAN_INPUT_MASK_RST; // R1
      st_r.s3_temp_voltage_mask <= `S3_TEMP_VOLTAGE_MASK_RST; // R2 R5
      st_r.s45_input_mask       <= `S45_INPUT_MASK_RST; // R4
      st_r.sleep_state          <= sleep_mask_pkg::SLEEP_OFF; // R7
      st_r.rd_data              <= 8'h00;
      st_r.rd_valid             <= 1'b0;
      st_r.err_rep              <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata   = st_r.rd_data;
  assign reg_rvalid  = st_r.rd_valid;
  assign err_rep     = st_r.err_rep;
  assign sleep_state = st_r.sleep_state;

endmodule

// file: verif/reg_host.sv
// Bus host model issuing register reads and writes.
// Assumes one-cycle strobes taken on the rising edge.
`timescale 1ns/100ps
module reg_host (
  input  wire logic               mclk,
  input  wire logic [7:0]         reg_rdata,
  input  wire logic               reg_rvalid,
  output sleep_mask_pkg::reg_req_t reg_req
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    reg_req = '{1'b0, 1'b0, ~a, 8'hff};
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule

// file: verif/sleep_mask_props.sv
// Checker for the sleep-state error mask bank.
// Assumes it is bound to the bank's top module.
`timescale 1ns/100ps
module sleep_mask_props (
  // Watched ports.
  input wire logic                         mclk,
  input wire logic                         rst_n,
  input wire logic                         reset_in,
  input wire sleep_mask_pkg::reg_req_t     reg_req,
  input wire sleep_mask_pkg::err_vec_t     err_raw,
  input wire sleep_mask_pkg::err_vec_t     err_rep,
  input wire sleep_mask_pkg::sleep_state_t sleep_state
);
  logic [3:0] fan_r, tv_r;
  logic [7:0] gpi_r;
  logic [1:0] st_r;
  logic       ok_r;
  always_ff @(posedge mclk) begin
    ok_r <= rst_n;
    st_r <= sleep_state;
    if (!rst_n) begin
      fan_r <= 4'hf;
      tv_r  <= 4'h7;
      gpi_r <= 8'hff;
    end else if (reg_req.wr) begin
      if (reg_req.addr == 8'he8) fan_r <= reg_req.wdata[3:0];
      if (reg_req.addr == 8'he9) tv_r <= reg_req.wdata[3:0];
      if (reg_req.addr == 8'hea) gpi_r <= reg_req.wdata;
    end
  end
  wire deep = ok_r && st_r == 2'b10;
  wire off  = ok_r && st_r == 2'b11;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_fan_deep_mask: assert property (deep |-> err_rep.fan ==
    $past(err_raw.fan & ~fan_r)) else $error("fan mask");
  a_zone_deep_mask: assert property (deep |->
    err_rep.zone_temp == $past(err_raw.zone_temp & ~tv_r[3]))
    else $error("zone mask");
  a_analog_deep_mask: assert property (deep |->
    err_rep.analog == $past(err_raw.analog & ~tv_r[2:0]))
    else $error("analog mask");
  a_low_gpi_mask: assert property (off |-> err_rep.gpi[3:0] ==
    $past(err_raw.gpi[3:0] & ~gpi_r[3:0])) else $error("gpi low");
  a_high_gpi_mask: assert property (off |-> err_rep.gpi[7:4] ==
    $past(err_raw.gpi[7:4] & ~gpi_r[7:4])) else $error("gpi high");
  a_working_pass: assert property (ok_r && st_r == 2'b00 |->
    err_rep == $past(err_raw)) else $error("working mask");
  a_off_other_pass: assert property (off |->
    err_rep[7:0] == $past(err_raw[7:0])) else $error("off mask");
  a_deep_gpi_pass: assert property (deep |->
    err_rep.gpi == $past(err_raw.gpi)) else $error("deep gpi");
  a_light_pass: assert property (ok_r && st_r == 2'b01 |->
    err_rep == $past(err_raw)) else $error("light mask");
  a_reset_forces_off: assert property (reset_in |=>
    sleep_state == 2'b11) else $error("reset state");
  c_deep: cover property (deep && err_raw.fan != 4'h0);
  c_off: cover property (off && reg_req.wr);
  c_rst: cover property (reset_in);
endmodule
bind sleep_state_error_masks sleep_mask_props i_sleep_mask_props (
  .mclk(mclk), .rst_n(rst_n), .reset_in(reset_in), .reg_req(reg_req),
  .err_raw(err_raw), .err_rep(err_rep), .sleep_state(sleep_state));

// file: verif/testbench.sv
// Self-checking bench for the sleep-state error mask bank.
// Assumes the host model and checker are compiled first.
`timescale 1ns/100ps
module testbench;
  logic                     mclk = 1'b0, rst_n = 1'b0;
  logic                     reset_in = 1'b0, state_wr = 1'b0;
  logic [1:0]               state_wdata = 2'b00;
  logic [7:0]               reg_rdata, d;
  logic                     reg_rvalid;
  sleep_mask_pkg::err_vec_t err_raw = '1, err_rep;
  sleep_mask_pkg::reg_req_t reg_req;
  sleep_mask_pkg::sleep_state_t sleep_state;
  int                       err_total = 0, total_checks = 0, cyc = 0;
  always #50 mclk = ~mclk;
  sleep_state_error_masks i_sleep_state_error_masks (.mclk(mclk),
    .rst_n(rst_n), .reset_in(reset_in), .state_wr(state_wr),
    .state_wdata(state_wdata), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .err_raw(err_raw), .err_rep(err_rep),
    .sleep_state(sleep_state));
  reg_host i_reg_host (.mclk(mclk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_req(reg_req));
  task automatic chk_err(input logic [15:0] g, input logic [15:0] x);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] x);
    chk_err({8'h00, g}, {8'h00, x});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    i_reg_host.rd(a, d);
    chk_reg(d, x);
  endtask
  task automatic echk(input logic [15:0] x);
    @(negedge mclk);
    chk_err(err_rep, x);
  endtask
  task automatic go(input logic [1:0] s);
    @(negedge mclk);
    state_wdata = s;
    state_wr = 1'b1;
    @(negedge mclk);
    state_wr = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 400) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk_reg({6'h00, sleep_state}, 8'h03);
    rchk(8'he8, 8'h0f);
    rchk(8'he9, 8'h07);
    rchk(8'hea, 8'hff);
    rchk(8'hf0, 8'h00);
    echk(16'h00ff);
    i_reg_host.wr(8'hea, 8'h5a);
    echk(16'ha5ff);
    go(2'b10);
    echk(16'hff80);
    i_reg_host.wr(8'he9, 8'h08);
    i_reg_host.wr(8'he8, 8'hf5);
    rchk(8'he8, 8'h05);
    rchk(8'he9, 8'h08);
    i_reg_host.wr(8'hf0, 8'hff);
    rchk(8'hea, 8'h5a);
    echk(16'hff7a);
    go(2'b00);
    echk(16'hffff);
    go(2'b01);
    echk(16'hffff);
    reset_in = 1'b1;
    go(2'b10);
    reset_in = 1'b0;
    chk_reg({6'h00, sleep_state}, 8'h03);
    echk(16'ha5ff);
    results();
  end
endmodule
